// ### rtl/pbc_regs.sv
// Basic control/status register pair behind a serial management slave
module pbc_regs
  import pbc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic [4:0] phy_addr_strap_i,
  input wire logic interrupt_powerdown_pin_n_i,
  input wire logic an_started_i,
  input wire logic an_done_i,
  input wire logic an_speed_100_i,
  input wire logic an_full_duplex_i,
  input wire logic far_end_fault_i,
  input wire logic remote_fault_i,
  input wire logic link_ok_i,
  input wire logic jabber_i,
  input wire logic tx_en_i,
  output logic col_o,
  output logic powerdown_o,
  output logic isolate_o,
  output logic an_enable_o,
  output logic an_restart_o,
  output logic speed_100_o,
  output logic full_duplex_o
);

  // ==========================================================
  // Input synchronisers
  logic mdc_s;
  logic mdio_s;
  logic pin_n_s;
  logic [4:0] strap_s;

  pbc_sync #(
    .WIDTH(8),
    .RST_VAL(8'h06)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({phy_addr_strap_i, interrupt_powerdown_pin_n_i, mdio_i, mdc_i}),
    .q_o({strap_s, pin_n_s, mdio_s, mdc_s})
  );

  // ==========================================================
  // Strap capture and clock edge
  logic mdc_prev_q;
  logic [1:0] strap_cnt_q;
  logic [4:0] phy_addr_q;
  logic mdc_rise;

  // Strap chain needs two cycles to settle; last capture lands one edge later
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mdc_prev_q <= 1'h0;
      strap_cnt_q <= 2'h0;
      phy_addr_q <= 5'h00;
    end
    else
    begin
      mdc_prev_q <= mdc_s;
      if (strap_cnt_q != PBC_STRAP_WAIT + 2'h1)
      begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
        phy_addr_q <= strap_s;
      end
    end
  end

  assign mdc_rise = mdc_s & ~mdc_prev_q;

  // ==========================================================
  // Register state
  logic speed_q, speed_d;
  logic an_en_q, an_en_d;
  logic pdown_q, pdown_d;
  logic iso_q, iso_d;
  logic restart_q, restart_d;
  logic duplex_q, duplex_d;
  logic coltest_q, coltest_d;
  logic rfault_q, rfault_d;
  logic link_q, link_d;
  logic jabber_q, jabber_d;
  logic col_q, col_d;
  logic spd_out_q, spd_out_d;
  logic dup_out_q, dup_out_d;
  logic pd_out_q, pd_out_d;
  logic [15:0] ctrl_word;
  logic [15:0] stat_word;
  logic an_complete;

  // Write and read strobes from the frame engine
  logic wr_stb;
  logic rd_stb;
  logic [4:0] regad_q;
  logic [15:0] wr_data;

  assign an_complete = an_done_i & an_en_q & ~restart_q; // R14

  always_comb
  begin
    // Bits 15, 14 and 6:0 stay zero
    ctrl_word = 16'h0000; // R22
    ctrl_word[PBC_C_SPEED] = speed_q;
    ctrl_word[PBC_C_AN_EN] = an_en_q;
    ctrl_word[PBC_C_PDOWN] = pdown_q;
    ctrl_word[PBC_C_ISOLATE] = iso_q;
    ctrl_word[PBC_C_RESTART] = restart_q; // R06
    ctrl_word[PBC_C_DUPLEX] = duplex_q;
    ctrl_word[PBC_C_COLTEST] = coltest_q;
    stat_word = 16'h0000; // R22
    stat_word[PBC_S_T4] = 1'h0; // R11
    stat_word[PBC_S_ABIL_HI:PBC_S_ABIL_LO] = PBC_ABILITIES; // R12
    stat_word[PBC_S_PRE_SUP] = 1'h1; // R13
    stat_word[PBC_S_AN_DONE] = an_complete; // R14
    stat_word[PBC_S_RFAULT] = rfault_q;
    stat_word[PBC_S_AN_ABLE] = 1'h1; // R16
    stat_word[PBC_S_LINK] = link_q;
    stat_word[PBC_S_JABBER] = jabber_q;
    stat_word[PBC_S_EXT] = PBC_EXT_CAP;
  end

  always_comb
  begin
    speed_d = speed_q;
    an_en_d = an_en_q;
    pdown_d = pdown_q;
    iso_d = iso_q;
    duplex_d = duplex_q;
    coltest_d = coltest_q;
    restart_d = restart_q;
    if (wr_stb && regad_q == PBC_REG_CONTROL)
    begin
      speed_d = wr_data[PBC_C_SPEED];
      an_en_d = wr_data[PBC_C_AN_EN]; // R21
      pdown_d = wr_data[PBC_C_PDOWN];
      iso_d = wr_data[PBC_C_ISOLATE];
      duplex_d = wr_data[PBC_C_DUPLEX]; // R08
      coltest_d = wr_data[PBC_C_COLTEST];
    end
    if (!pin_n_s)
      pdown_d = 1'h1; // R03
    if (an_started_i)
      restart_d = 1'h0; // R06
    // A zero written here leaves a pending restart alone
    if (wr_stb && regad_q == PBC_REG_CONTROL && wr_data[PBC_C_RESTART] && an_en_d)
      restart_d = 1'h1; // R05 R07
    if (!an_en_d)
      restart_d = 1'h0; // R05
    // Latched bits: a new event beats the clearing read
    rfault_d = rd_stb ? 1'h0 : rfault_q;
    if (far_end_fault_i || remote_fault_i)
      rfault_d = 1'h1; // R15 R19
    link_d = rd_stb ? link_ok_i : (link_q & link_ok_i); // R17 R20
    jabber_d = rd_stb ? 1'h0 : jabber_q;
    if (jabber_i && !spd_out_q)
      jabber_d = 1'h1; // R18 R19
    // Registered echo of TX_EN meets both limits in one cycle
    col_d = coltest_q & tx_en_i & ~iso_q & ~pd_out_q; // R09 R10 R04
    spd_out_d = an_en_q ? an_speed_100_i : speed_q; // R01
    dup_out_d = an_en_q ? an_full_duplex_i : duplex_q; // R01 R08
    pd_out_d = pdown_q | ~pin_n_s; // R02 R03
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      speed_q <= PBC_RST_SPEED;
      an_en_q <= PBC_RST_AN_EN;
      pdown_q <= 1'h0;
      iso_q <= 1'h0;
      restart_q <= 1'h0;
      duplex_q <= PBC_RST_DUPLEX;
      coltest_q <= 1'h0;
      rfault_q <= 1'h0;
      link_q <= 1'h0;
      jabber_q <= 1'h0;
      col_q <= 1'h0;
      spd_out_q <= PBC_RST_SPEED;
      dup_out_q <= PBC_RST_DUPLEX;
      pd_out_q <= 1'h0;
    end
    else
    begin
      speed_q <= speed_d;
      an_en_q <= an_en_d;
      pdown_q <= pdown_d;
      iso_q <= iso_d;
      restart_q <= restart_d;
      duplex_q <= duplex_d;
      coltest_q <= coltest_d;
      rfault_q <= rfault_d;
      link_q <= link_d;
      jabber_q <= jabber_d;
      col_q <= col_d;
      spd_out_q <= spd_out_d;
      dup_out_q <= dup_out_d;
      pd_out_q <= pd_out_d;
    end
  end

  assign col_o = col_q;
  assign powerdown_o = pd_out_q; // R02
  assign isolate_o = iso_q; // R04
  assign an_enable_o = an_en_q; // R21
  assign an_restart_o = restart_q;
  assign speed_100_o = spd_out_q;
  assign full_duplex_o = dup_out_q;

  // ==========================================================
  // Management frame engine
  pbc_state_type state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] shift_q, shift_d;
  logic is_read_q, is_read_d;
  logic match_q, match_d;
  logic [4:0] regad_d;
  logic mdio_o_q, mdio_o_d;
  logic mdio_oe_q, mdio_oe_d;
  logic [15:0] rd_word;

  always_comb
  begin
    if (regad_q == PBC_REG_CONTROL)
      rd_word = ctrl_word;
    else if (regad_q == PBC_REG_STATUS)
      rd_word = stat_word;
    else
      rd_word = 16'h0000;
  end

  // Power down and isolate leave this engine running
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    is_read_d = is_read_q;
    match_d = match_q;
    regad_d = regad_q;
    mdio_o_d = mdio_o_q;
    mdio_oe_d = mdio_oe_q;
    wr_stb = 1'h0;
    rd_stb = 1'h0;
    wr_data = {shift_q[14:0], mdio_s};
    if (mdc_rise)
    begin
      case (state_q)
        PBC_ST_PRE:
        begin
          cnt_d = 5'h00;
          if (mdio_s && cnt_q == 5'(PBC_PREAMBLE_BITS - 1))
            state_d = PBC_ST_IDLE; // R13
          else if (mdio_s)
            cnt_d = cnt_q + 5'h01;
        end
        PBC_ST_IDLE:
        begin
          if (!mdio_s)
            state_d = PBC_ST_START;
        end
        PBC_ST_START:
        begin
          cnt_d = 5'h00;
          state_d = mdio_s ? PBC_ST_OP : PBC_ST_PRE;
        end
        PBC_ST_OP:
        begin
          shift_d = {shift_q[14:0], mdio_s};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'h01)
          begin
            cnt_d = 5'h00;
            is_read_d = ({shift_q[0], mdio_s} == PBC_OP_READ);
            // Bad opcode asks for a fresh preamble
            if ({shift_q[0], mdio_s} == PBC_OP_READ || {shift_q[0], mdio_s} == PBC_OP_WRITE)
              state_d = PBC_ST_ADDR;
            else
              state_d = PBC_ST_PRE; // R13
          end
        end
        PBC_ST_ADDR:
        begin
          shift_d = {shift_q[14:0], mdio_s};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'(PBC_ADDR_BITS - 1))
          begin
            cnt_d = 5'h00;
            match_d = (shift_q[8:4] == phy_addr_q);
            regad_d = {shift_q[3:0], mdio_s};
            state_d = PBC_ST_TA;
          end
        end
        PBC_ST_TA:
        begin
          cnt_d = 5'h01;
          if (cnt_q == 5'h00)
          begin
            if (is_read_q)
            begin
              mdio_oe_d = match_q;
              mdio_o_d = 1'h0;
            end
            else if (!mdio_s)
            begin
              // Full preamble count again, not a stale one
              cnt_d = 5'h00;
              state_d = PBC_ST_PRE; // R13
            end
          end
          else
          begin
            cnt_d = 5'h00;
            if (is_read_q)
            begin
              shift_d = rd_word;
              mdio_o_d = rd_word[PBC_DATA_BITS-1];
              rd_stb = match_q && regad_q == PBC_REG_STATUS;
              state_d = PBC_ST_DATA;
            end
            else
              state_d = mdio_s ? PBC_ST_PRE : PBC_ST_DATA; // R13
          end
        end
        PBC_ST_DATA:
        begin
          cnt_d = cnt_q + 5'h01;
          if (is_read_q)
          begin
            shift_d = {shift_q[14:0], 1'h0};
            mdio_o_d = shift_q[PBC_DATA_BITS-2];
          end
          else
            shift_d = {shift_q[14:0], mdio_s};
          if (cnt_q == 5'(PBC_DATA_BITS - 1))
          begin
            cnt_d = 5'h00;
            mdio_oe_d = 1'h0;
            mdio_o_d = 1'h0;
            wr_stb = ~is_read_q & match_q;
            state_d = PBC_ST_IDLE; // R13
          end
        end
        default:
        begin
          state_d = PBC_ST_PRE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= PBC_ST_PRE;
      cnt_q <= 5'h00;
      shift_q <= 16'h0000;
      is_read_q <= 1'h0;
      match_q <= 1'h0;
      regad_q <= 5'h00;
      mdio_o_q <= 1'h0;
      mdio_oe_q <= 1'h0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      is_read_q <= is_read_d;
      match_q <= match_d;
      regad_q <= regad_d;
      mdio_o_q <= mdio_o_d;
      mdio_oe_q <= mdio_oe_d;
    end
  end

  assign mdio_o = mdio_o_q;
  assign mdio_oe_o = mdio_oe_q;

endmodule

// ### rtl/pbc_pkg.sv
// Constants for the basic mode control and status register pair
// Notes on behaviour
// R01: Negotiation off: speed bit 13, duplex bit 8
// R02: Bit 11 powers down; management access stays
// R03: Power down is bit 11 OR pin
// R04: Bit 10 isolates port from MII signals
// R05: Restart write ignored while negotiation disabled
// R06: Restart reads 1 until negotiation begins
// R07: Writing 0 to restart changes nothing
// R08: Bit 8 selects full or half duplex
// R09: Collision test: COL within 512 bit times
// R10: Collision test: COL drops within 4 bits
// R11: Status bit 15 always reads 0
// R12: Status bits 14 to 11 read 1
// R13: Preamble needed once; bit 6 reads 1
// R14: Status bit 5 set only when finished
// R15: Remote fault latches high, read clears
// R16: Status bit 3 reads 1
// R17: Link status latches low until read
// R18: Jabber latches high, only at 10 Mbps
// R19: Latched-high bit holds 1 until read
// R20: Latched-low bit holds 0 until read
// R21: Bit 12 enables automatic negotiation
// R22: Reserved bits read zero, ignore writes
package pbc_pkg;

  // ==========================================================
  // Register map
  localparam logic [4:0] PBC_REG_CONTROL = 5'h00;
  localparam logic [4:0] PBC_REG_STATUS = 5'h01;

  // ==========================================================
  // Control register fields
  localparam int PBC_C_SPEED = 13;
  localparam int PBC_C_AN_EN = 12;
  localparam int PBC_C_PDOWN = 11;
  localparam int PBC_C_ISOLATE = 10;
  localparam int PBC_C_RESTART = 9;
  localparam int PBC_C_DUPLEX = 8;
  localparam int PBC_C_COLTEST = 7;
  localparam logic PBC_RST_SPEED = 1'h1;
  localparam logic PBC_RST_AN_EN = 1'h1;
  localparam logic PBC_RST_DUPLEX = 1'h1;

  // ==========================================================
  // Status register fields
  localparam int PBC_S_T4 = 15;
  localparam int PBC_S_ABIL_HI = 14;
  localparam int PBC_S_ABIL_LO = 11;
  localparam int PBC_S_PRE_SUP = 6;
  localparam int PBC_S_AN_DONE = 5;
  localparam int PBC_S_RFAULT = 4;
  localparam int PBC_S_AN_ABLE = 3;
  localparam int PBC_S_LINK = 2;
  localparam int PBC_S_JABBER = 1;
  localparam int PBC_S_EXT = 0;
  localparam logic [3:0] PBC_ABILITIES = 4'hf;
  localparam logic PBC_EXT_CAP = 1'h1;

  // ==========================================================
  // Management frame
  localparam int PBC_PREAMBLE_BITS = 32;
  localparam logic [1:0] PBC_OP_READ = 2'h2;
  localparam logic [1:0] PBC_OP_WRITE = 2'h1;
  localparam int PBC_ADDR_BITS = 10;
  localparam int PBC_DATA_BITS = 16;

  // ==========================================================
  // Timing
  localparam int PBC_CLK_PERIOD_NS = 25;
  localparam int PBC_BIT_TIME_NS = 10;
  localparam int PBC_COL_ON_BITS = 512;
  localparam int PBC_COL_OFF_BITS = 4;
  localparam int PBC_COL_ON_RAW = (PBC_COL_ON_BITS * PBC_BIT_TIME_NS) / PBC_CLK_PERIOD_NS;
  localparam int PBC_COL_OFF_RAW = (PBC_COL_OFF_BITS * PBC_BIT_TIME_NS) / PBC_CLK_PERIOD_NS;
  localparam int PBC_COL_ON_CYCLES = (PBC_COL_ON_RAW < 1) ? 1 : PBC_COL_ON_RAW;
  localparam int PBC_COL_OFF_CYCLES = (PBC_COL_OFF_RAW < 1) ? 1 : PBC_COL_OFF_RAW;
  localparam logic [1:0] PBC_STRAP_WAIT = 2'h2;

  typedef enum logic [2:0] {
    PBC_ST_PRE,
    PBC_ST_IDLE,
    PBC_ST_START,
    PBC_ST_OP,
    PBC_ST_ADDR,
    PBC_ST_TA,
    PBC_ST_DATA
  } pbc_state_type;

endpackage

// ### rtl/pbc_sync.sv
// Two flip-flop synchroniser, one chain per bit
module pbc_sync
  import pbc_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;

  // ==========================================================
  // Chains
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        meta_q[i] <= RST_VAL[i];
        q_o[i] <= RST_VAL[i];
      end
      else
      begin
        meta_q[i] <= d_i[i];
        q_o[i] <= meta_q[i];
      end
    end
  end

endmodule

// ### tb/pbc_regs_asserts.sv
// Port-level assertions for the basic control/status register block
module pbc_regs_asserts
  import pbc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic interrupt_powerdown_pin_n_i,
  input wire logic an_started_i,
  input wire logic an_speed_100_i,
  input wire logic an_full_duplex_i,
  input wire logic tx_en_i,
  input wire logic mdio_o,
  input wire logic mdio_oe_o,
  input wire logic col_o,
  input wire logic powerdown_o,
  input wire logic an_enable_o,
  input wire logic an_restart_o,
  input wire logic speed_100_o,
  input wire logic full_duplex_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Sequences
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_pin_low;
    !interrupt_powerdown_pin_n_i [*4];
  endsequence
  sequence s_oe_hold;
    mdio_oe_o [*8];
  endsequence
  // Reset edge excluded: outputs are forced there
  sequence s_an_steady;
    !$past(rst_i) && $past(an_enable_o, 2) && $past(an_enable_o) && an_enable_o;
  endsequence
  // ====================
  // Properties
  property p_col_cause;
    $rose(col_o) |-> $past(tx_en_i);
  endproperty
  property p_col_off;
    !tx_en_i |=> !col_o;
  endproperty
  property p_speed;
    s_an_steady |-> speed_100_o == $past(an_speed_100_i);
  endproperty
  property p_duplex;
    s_an_steady |-> full_duplex_o == $past(an_full_duplex_i);
  endproperty
  property p_pin;
    s_pin_low |=> powerdown_o;
  endproperty
  property p_rst_clear;
    an_restart_o && an_started_i |-> ##[1:2] !an_restart_o;
  endproperty
  property p_rst_hold;
    an_restart_o && an_enable_o && !an_started_i && !$past(an_started_i) |=> an_restart_o || !an_enable_o;
  endproperty
  property p_ta;
    $rose(mdio_oe_o) |-> !mdio_o ##1 s_oe_hold;
  endproperty
  a_col_cause: assert property (p_col_cause) else $error("collision without transmit enable");
  a_col_off: assert property (p_col_off) else $error("collision held after transmit end");
  a_speed: assert property (p_speed) else $error("speed not taken from negotiation");
  a_duplex: assert property (p_duplex) else $error("duplex not taken from negotiation");
  a_pin: assert property (p_pin) else $error("pin low without power down");
  a_rst_clear: assert property (p_rst_clear) else $error("restart not cleared on start");
  a_rst_hold: assert property (p_rst_hold) else $error("pending restart lost");
  a_ta: assert property (p_ta) else $error("bad read turnaround drive");
endmodule

bind pbc_regs pbc_regs_asserts i_chk (.clk_i, .rst_i, .interrupt_powerdown_pin_n_i, .an_started_i,
  .an_speed_100_i, .an_full_duplex_i, .tx_en_i, .mdio_o, .mdio_oe_o, .col_o, .powerdown_o, .an_enable_o,
  .an_restart_o, .speed_100_o, .full_duplex_o);

// ### tb/pbc_mgr_model.sv
// Station manager model sending management frames on the serial clock and data lines
module pbc_mgr_model
  import pbc_pkg::*;
(
  input wire logic mdio_i,
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic need_pre;
  // Serial clock stands low between frames
  initial
  begin
    mdc_o = 1'b0;
    mdio_o = 1'b0;
    mdio_oe_o = 1'b0;
    need_pre = 1'b1;
  end
  task automatic bit_out(input logic b);
    mdio_oe_o = 1'b1;
    mdio_o = b;
    #100 mdc_o = 1'b1;
    #100 mdc_o = 1'b0;
  endtask
  task automatic bit_in(output logic b);
    mdio_oe_o = 1'b0;
    #100 b = mdio_i;
    mdc_o = 1'b1;
    #100 mdc_o = 1'b0;
  endtask
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [13:0] hdr;
    logic b;
    hdr = {2'b01, op, pa, ra};
    rd = 16'h0000;
    // Preamble before the first frame and whenever need_pre is set again
    if (need_pre)
      repeat (PBC_PREAMBLE_BITS) bit_out(1'b1);
    need_pre = 1'b0;
    for (int i = 13; i >= 0; i--)
      bit_out(hdr[i]);
    if (op == PBC_OP_WRITE)
    begin
      bit_out(1'b1);
      bit_out(1'b0);
      for (int i = 15; i >= 0; i--)
        bit_out(wd[i]);
    end
    else
    begin
      repeat (2) bit_in(b);
      for (int i = 15; i >= 0; i--)
        bit_in(rd[i]);
    end
    mdio_oe_o = 1'b0;
  endtask
endmodule

// ### tb/pbc_regs_tb.sv
// Self-checking bench for the basic control/status register block
module pbc_regs_tb
  import pbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] PA = 5'h0b;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pin_n = 1'b1, a_st = 1'b0, a_dn = 1'b0, a_sp = 1'b0, a_fd = 1'b1;
  logic ff = 1'b0, rf = 1'b0, lok = 1'b0, jab = 1'b0, tx = 1'b0;
  logic mdc, m_d, m_en, mdio_w, d_o, d_oe, col, pd, iso, ane, anr, spd, fd;
  logic [15:0] v, d;
  logic [15:0] cn [4] = '{16'h0480, 16'h0880, 16'h2100, 16'h007f};
  int mismatches = 0;
  int check_count = 0;
  // ====================
  // Clock, pulled-up data wire, instances
  always #12.5 clk_i = ~clk_i;
  assign mdio_w = d_oe ? d_o : (m_en ? m_d : 1'b1);
  pbc_mgr_model i_mgr (.mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(m_d), .mdio_oe_o(m_en));
  pbc_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(d_o), .mdio_oe_o(d_oe),
    .phy_addr_strap_i(PA), .interrupt_powerdown_pin_n_i(pin_n), .an_started_i(a_st), .an_done_i(a_dn),
    .an_speed_100_i(a_sp), .an_full_duplex_i(a_fd), .far_end_fault_i(ff), .remote_fault_i(rf),
    .link_ok_i(lok), .jabber_i(jab), .tx_en_i(tx), .col_o(col), .powerdown_o(pd), .isolate_o(iso),
    .an_enable_o(ane), .an_restart_o(anr), .speed_100_o(spd), .full_duplex_o(fd));
  // ====================
  // Helpers
  function automatic logic [15:0] st(input logic dn, r, l, j);
    return {1'b0, 4'hf, 4'h0, 1'b1, dn, r, 1'b1, l, j, PBC_EXT_CAP};
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Realign to the falling edge after each frame
  task automatic xf(input logic [1:0] op, input logic [4:0] pa, ra, input logic [15:0] w,
                    output logic [15:0] r);
    i_mgr.xfer(op, pa, ra, w, r);
    cyc(4);
  endtask
  task automatic rd(input logic [4:0] ra, output logic [15:0] r);
    xf(PBC_OP_READ, PA, ra, 16'h0000, r);
  endtask
  task automatic wr(input logic [15:0] w);
    logic [15:0] r;
    xf(PBC_OP_WRITE, PA, PBC_REG_CONTROL, w, r);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ====================
  // Tests
  initial
  begin
    void'($urandom(32'hf8d054c1));
    cyc(12);
    rst_i = 1'b0;
    cyc(6);
    rd(PBC_REG_CONTROL, v);
    chk("ctl_rst", v, 16'h3100);
    lok = 1'b1;
    ff = 1'b1;
    jab = 1'b1;
    cyc(1);
    ff = 1'b0;
    jab = 1'b0;
    rd(PBC_REG_STATUS, v);
    chk("st_latch", v, st(1'b0, 1'b1, 1'b0, 1'b1));
    rd(PBC_REG_STATUS, v);
    chk("st_clear", v, st(1'b0, 1'b0, 1'b1, 1'b0));
    lok = 1'b0;
    rf = 1'b1;
    cyc(1);
    lok = 1'b1;
    rf = 1'b0;
    rd(PBC_REG_STATUS, v);
    chk("st_loss", v, st(1'b0, 1'b1, 1'b0, 1'b0));
    rd(PBC_REG_STATUS, v);
    chk("st_back", v, st(1'b0, 1'b0, 1'b1, 1'b0));
    for (int i = 0; i < 8; i++)
    begin
      d = (i < 4) ? cn[i] : 16'($urandom) & 16'hfdff;
      tx = (i < 4) ? 1'b1 : 1'($urandom);
      a_sp = 1'($urandom);
      wr(d);
      rd(PBC_REG_CONTROL, v);
      chk("ctl", v, d & 16'h3d80);
      chk("iso_pd_an", {iso, pd, ane}, {d[10], d[11], d[12]});
      chk("spd_dup", {spd, fd}, d[12] ? {a_sp, a_fd} : {d[13], d[8]});
      chk("col", col, d[7] & tx & !d[10] & !d[11]);
    end
    wr(16'h0080);
    tx = 1'b1;
    cyc(2);
    chk("col_on", col, 1'b1);
    tx = 1'b0;
    cyc(2);
    chk("col_off", col, 1'b0);
    a_dn = 1'b1;
    wr(16'h1200);
    rd(PBC_REG_CONTROL, v);
    chk("rst_pend", v, 16'h1200);
    chk("anr_pend", anr, 1'b1);
    rd(PBC_REG_STATUS, v);
    chk("st_pend", v, st(1'b0, 1'b0, 1'b1, 1'b0));
    wr(16'h1000);
    rd(PBC_REG_CONTROL, v);
    chk("rst_keep", v, 16'h1200);
    a_st = 1'b1;
    cyc(1);
    a_st = 1'b0;
    rd(PBC_REG_CONTROL, v);
    chk("rst_self", v, 16'h1000);
    chk("anr_self", anr, 1'b0);
    rd(PBC_REG_STATUS, v);
    chk("st_done", v, st(1'b1, 1'b0, 1'b1, 1'b0));
    wr(16'h0200);
    rd(PBC_REG_CONTROL, v);
    chk("rst_ign", v, 16'h0000);
    rd(PBC_REG_STATUS, v);
    chk("st_off", v, st(1'b0, 1'b0, 1'b1, 1'b0));
    pin_n = 1'b0;
    cyc(6);
    chk("pd_pin", pd, 1'b1);
    rd(PBC_REG_CONTROL, v);
    chk("ctl_pin", v, 16'h0800);
    pin_n = 1'b1;
    cyc(4);
    wr(16'h0000);
    chk("pd_off", pd, 1'b0);
    rd(5'h05, v);
    chk("unmapped", v, 16'h0000);
    xf(PBC_OP_READ, PA ^ 5'h01, PBC_REG_STATUS, 16'h0000, v);
    chk("other_addr", v, 16'hffff);
    wr(16'h2000);
    jab = 1'b1;
    cyc(1);
    jab = 1'b0;
    rd(PBC_REG_STATUS, v);
    chk("jab_100", v, st(1'b0, 1'b0, 1'b1, 1'b0));
    // Bad opcode: the next frame without preamble must be ignored
    xf(2'h3, PA, PBC_REG_CONTROL, 16'h0000, v);
    rd(PBC_REG_CONTROL, v);
    chk("no_pre", v, 16'hffff);
    i_mgr.need_pre = 1'b1;
    rd(PBC_REG_CONTROL, v);
    chk("pre_again", v, 16'h2000);
    test_done();
  end
  initial
  begin
    #1000000;
    mismatches++;
    test_done();
  end
endmodule
